/* rtl/rlt_pkg.sv */
/*
 * Package for the reloadable 8-bit up timer: register indices, field
 * positions, reset values, clock-source codes and prescaler divisors.
 * Assumes a plain single-cycle register port with 8-bit data.
 */
package rlt_pkg;

    // Register indices on the plain register port
    localparam logic [1:0] ADDR_MODE      = 2'h0;
    localparam logic [1:0] ADDR_COUNT     = 2'h1;
    localparam logic [1:0] ADDR_IRQ       = 2'h2;
    localparam logic [1:0] ADDR_CTRL      = 2'h3;

    // Mode register fields
    localparam int         MODE_RELOAD_BIT = 7;
    localparam logic [7:0] MODE_RSVD_MASK  = 8'h78;
    localparam logic [7:0] MODE_RESET      = 8'h78;
    localparam logic [2:0] SRC_RESET       = 3'h0;
    localparam logic [2:0] SRC_EVENT       = 3'h7;

    // Interrupt register fields: flag and enable
    localparam int         IRQ_FLAG_BIT   = 0;
    localparam int         IRQ_EN_BIT     = 1;

    // Control register fields: edge select, power state
    localparam int         CTRL_EDGE_BIT  = 0;
    localparam int         CTRL_HALT_BIT  = 1;

    localparam logic [7:0] COUNT_RESET    = 8'h00;
    localparam logic [7:0] RELOAD_RESET   = 8'h00;
    localparam logic [7:0] COUNT_MAX      = 8'hff;

    // Prescaler divisors per source code 0..6
    localparam int         DIV_0          = 8192;
    localparam int         DIV_1          = 2048;
    localparam int         DIV_2          = 512;
    localparam int         DIV_3          = 256;
    localparam int         DIV_4          = 64;
    localparam int         DIV_5          = 16;
    localparam int         DIV_6          = 4;
    localparam int         PRESCALE_W     = 13;

endpackage : rlt_pkg

/* rtl/rlt_timer.sv */
/*
 * Reloadable 8-bit up timer with interval and auto-reload modes and
 * external event counting.
 * Assumes a single-cycle register master on i_mclk and an asynchronous
 * event pin that is synchronised here.
 */
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module rlt_timer
(
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // Register port
    input  wire logic [1:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // Event pin and interrupt request
    input  wire logic       i_event_input_pin,
    output logic            o_irq
);

    logic                    reload_mode_select;
    logic [2:0]              clock_source_sel;
    logic                    overflow_request_flag;
    logic                    overflow_irq_enable;
    logic                    event_edge_select;
    logic                    halt;
    logic [7:0]              count_value;
    logic [7:0]              reload_value;
    logic [rlt_pkg::PRESCALE_W-1:0] prescale;
    logic [rlt_pkg::PRESCALE_W-1:0] prescale_prev;
    logic                    pin_s1;
    logic                    pin_s2;
    logic                    pin_s3;
    logic                    tick;
    logic                    overflow;
    logic                    wr_mode;
    logic                    wr_count;
    logic                    wr_irq;
    logic                    wr_ctrl;

    // Falling edge of prescaler bit gives one pulse per divisor period
    function automatic logic div_pulse(input int div);
        div_pulse = prescale_prev[$clog2(div)-1]
                    & ~prescale[$clog2(div)-1];
    endfunction : div_pulse

    assign wr_mode  = i_wr && (i_addr == rlt_pkg::ADDR_MODE);
    assign wr_count = i_wr && (i_addr == rlt_pkg::ADDR_COUNT);
    assign wr_irq   = i_wr && (i_addr == rlt_pkg::ADDR_IRQ);
    assign wr_ctrl  = i_wr && (i_addr == rlt_pkg::ADDR_CTRL);

    // Free-running prescaler; stops only while halted
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            prescale      <= '0;
            prescale_prev <= '0;
        end
        else if (!halt)
        begin
            prescale      <= prescale + 1'b1;
            prescale_prev <= prescale;
        end
    end

    // Two-stage synchroniser, third stage for edge detect
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
        end
        else
        begin
            pin_s1 <= i_event_input_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Source select; every source is a one-cycle enable
    always_comb
    begin
        unique case (clock_source_sel)
            3'h0:    tick = div_pulse(rlt_pkg::DIV_0);
            3'h1:    tick = div_pulse(rlt_pkg::DIV_1);
            3'h2:    tick = div_pulse(rlt_pkg::DIV_2);
            3'h3:    tick = div_pulse(rlt_pkg::DIV_3);
            3'h4:    tick = div_pulse(rlt_pkg::DIV_4);
            3'h5:    tick = div_pulse(rlt_pkg::DIV_5);
            3'h6:    tick = div_pulse(rlt_pkg::DIV_6);
            // Edge select 1 = rising, 0 = falling
            default: tick = event_edge_select ? (pin_s2 & ~pin_s3)
                                              : (~pin_s2 & pin_s3);
        endcase
    end

    // Same overflow in both modes
    assign overflow = tick && !halt && (count_value == rlt_pkg::COUNT_MAX);

    // Mode register; retained in every power state
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            reload_mode_select <= 1'b0;
            clock_source_sel   <= rlt_pkg::SRC_RESET;
        end
        else if (wr_mode)
        begin
            // Reserved bits are not stored
            reload_mode_select <= i_wdata[rlt_pkg::MODE_RELOAD_BIT];
            clock_source_sel   <= i_wdata[2:0];
        end
    end

    // Reload register, write-only at the counter address
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            reload_value <= rlt_pkg::RELOAD_RESET;
        else if (wr_count)
            reload_value <= i_wdata;
    end

    // Counter
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            count_value <= rlt_pkg::COUNT_RESET;
        else if (wr_count)
            count_value <= i_wdata;
        else if (overflow)
        begin
            // Reload gives 256 - reload input clocks per period
            if (reload_mode_select)
                count_value <= reload_value;
            else
                count_value <= '0;
        end
        else if (tick && !halt)
            count_value <= count_value + 8'h01;
    end

    // Overflow flag: set beats a software clear in the same cycle
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            overflow_request_flag <= 1'b0;
        else if (overflow)
            overflow_request_flag <= 1'b1;
        else if (wr_irq && !i_wdata[rlt_pkg::IRQ_FLAG_BIT])
            overflow_request_flag <= 1'b0;
    end

    // Interrupt enable, edge select and power state
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            overflow_irq_enable <= 1'b0;
            event_edge_select   <= 1'b0;
            halt                <= 1'b0;
        end
        else
        begin
            if (wr_irq)
                overflow_irq_enable <= i_wdata[rlt_pkg::IRQ_EN_BIT];
            if (wr_ctrl)
            begin
                event_edge_select <= i_wdata[rlt_pkg::CTRL_EDGE_BIT];
                // Written from the control register; stops the prescaler and the counter
                halt              <= i_wdata[rlt_pkg::CTRL_HALT_BIT];
            end
        end
    end

    // Interrupt request, gated by the enable
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_irq <= 1'b0;
        else
            o_irq <= (overflow_request_flag || overflow)
                     && overflow_irq_enable;
    end

    // Read data, one cycle after the strobe; zero in cycles without a read
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            unique case (i_addr)
                rlt_pkg::ADDR_MODE:
                    o_rdata <= {reload_mode_select, 4'hf, clock_source_sel}
                               | rlt_pkg::MODE_RSVD_MASK;
                rlt_pkg::ADDR_COUNT:
                    o_rdata <= count_value;
                rlt_pkg::ADDR_IRQ:
                    o_rdata <= {6'h00, overflow_irq_enable,
                                overflow_request_flag};
                default:
                    o_rdata <= {6'h00, halt, event_edge_select};
            endcase
        end
        else
            o_rdata <= 8'h00;
    end

endmodule : rlt_timer

/* test/rlt_timer_sva.sv */
/* Checker for rlt_timer ports: read-back, reset and irq gating.
   Assumes one-cycle strobes that never overlap. */
`timescale 1ns/1ps
module rlt_timer_chk (
    // Clock and reset
    input wire logic       i_mclk,
    input wire logic       i_rst,
    // Register port
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // Pins
    input wire logic       i_event_input_pin,
    input wire logic       o_irq
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // The bench tasks leave one idle cycle between a write and a read
    sequence s_wr_rd(a);
        i_wr && i_addr == a ##2 i_rd && i_addr == a;
    endsequence
    sequence s_rel;
        i_rst ##1 !i_rst ##1 i_rd && i_addr == 2'h1;
    endsequence
    property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
    property p_rsvd; i_rd && i_addr == 2'h0 |=> &o_rdata[6:3]; endproperty
    property p_mode;
        s_wr_rd(2'h0) |=> o_rdata == ($past(i_wdata, 3) | 8'h78);
    endproperty
    // A tick may land between write and read, so allow one step
    property p_load; s_wr_rd(2'h1) |=> o_rdata - $past(i_wdata, 3) <= 8'h01;
    endproperty
    property p_ien; s_wr_rd(2'h2) |=> o_rdata[1] == $past(i_wdata[1], 3);
    endproperty
    property p_ctl;
        s_wr_rd(2'h3) |=> o_rdata[1:0] == $past(i_wdata[1:0], 3);
    endproperty
    // Enable clears at the next edge, the registered request one later
    property p_off; i_wr && i_addr == 2'h2 && !i_wdata[1] |=> ##2 !o_irq;
    endproperty
    property p_rcnt; disable iff (1'b0) s_rel |=> o_rdata == 8'h00;
    endproperty
    property p_rirq; disable iff (1'b0) i_rst |=> !o_irq; endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");
    a_rsvd: assert property (p_rsvd) else $error("reserved bits");
    a_mode: assert property (p_mode) else $error("mode readback");
    a_load: assert property (p_load) else $error("reload to count");
    a_ien: assert property (p_ien) else $error("enable readback");
    a_ctl: assert property (p_ctl) else $error("ctrl readback");
    a_off: assert property (p_off) else $error("irq not masked");
    a_rcnt: assert property (p_rcnt) else $error("count not reset");
    a_rirq: assert property (p_rirq) else $error("irq in reset");
endmodule : rlt_timer_chk

bind rlt_timer rlt_timer_chk rlt_timer_chk_inst (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_event_input_pin(i_event_input_pin),
    .o_irq(o_irq));

/* test/tb_rlt_timer.sv */
/* Bench for rlt_timer: reads queue expectations checked by a monitor.
   Assumes a 200 MHz clock and event pin counting for fast tests. */
`timescale 1ns/1ps
module tb_rlt_timer;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic [1:0]  i_addr = 2'h0;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_event_input_pin = 1'b0;
    logic [7:0]  o_rdata;
    logic        o_irq;
    logic        rd_d = 1'b0;
    logic [7:0]  exp_q[$];
    logic [31:0] seed = 32'he0f0;
    logic [7:0]  r;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cyc = 0;
    always #2.5 i_mclk = ~i_mclk;
    rlt_timer rlt_timer_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_event_input_pin(i_event_input_pin),
        .o_irq(o_irq));
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Irq is a level, so a few cycles of settling are harmless
    task automatic chk_irq(logic e);
        repeat (3) @(negedge i_mclk);
        chk("irq", {7'h00, e}, {7'h00, o_irq});
    endtask : chk_irq
    task automatic wr(logic [1:0] a, logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [1:0] a, logic [7:0] e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_mclk);
        i_rd <= 1'b0;
    endtask : rd
    // Long halves leave room for the pin synchroniser
    task automatic pulse(int n);
        repeat (n)
        begin
            @(posedge i_mclk) i_event_input_pin <= 1'b1;
            repeat (6) @(posedge i_mclk);
            i_event_input_pin <= 1'b0;
            repeat (6) @(posedge i_mclk);
        end
    endtask : pulse
    task tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    always @(posedge i_mclk) rd_d <= i_rd;
    always @(negedge i_mclk)
    begin
        if (rd_d)
            chk("rdata", exp_q.pop_front(), o_rdata);
    end
    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(2'h1, 8'h00);
        rd(2'h0, 8'h78);
        rd(2'h2, 8'h00);
        repeat (8250) @(posedge i_mclk);
        rd(2'h1, 8'h01);
        wr(2'h0, 8'hff);
        rd(2'h0, 8'hff);
        $display("test reset and mode done");
        wr(2'h0, 8'h07);
        wr(2'h3, 8'h01);
        rd(2'h3, 8'h01);
        for (int k = 1; k < 4; k++)
        begin
            r = xs();
            wr(2'h1, r);
            rd(2'h1, r);
            pulse(k);
            rd(2'h1, r + 8'(k));
            rd(2'h1, r + 8'(k));
        end
        wr(2'h3, 8'h00);
        wr(2'h2, 8'h00);
        wr(2'h1, 8'hfe);
        pulse(2);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h01);
        chk_irq(1'b0);
        wr(2'h2, 8'h03);
        rd(2'h2, 8'h03);
        chk_irq(1'b1);
        wr(2'h2, 8'h00);
        chk_irq(1'b0);
        $display("test interval done");
        wr(2'h0, 8'h87);
        wr(2'h1, 8'hfd);
        pulse(3);
        rd(2'h1, 8'hfd);
        rd(2'h2, 8'h01);
        wr(2'h2, 8'h00);
        wr(2'h1, 8'hff);
        pulse(1);
        rd(2'h1, 8'hff);
        rd(2'h2, 8'h01);
        $display("test reload done");
        wr(2'h3, 8'h02);
        pulse(2);
        rd(2'h1, 8'hff);
        rd(2'h0, 8'hff);
        rd(2'h3, 8'h02);
        $display("test halt done");
        @(posedge i_mclk) i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(2'h1, 8'h00);
        rd(2'h0, 8'h78);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : tb_rlt_timer
